// [core/useq_pkg.sv]
// shared constants, types and register map of the rom microsequencer
package useq_pkg;
   localparam int unsigned STATE_W = 8;
   localparam int unsigned ROM_WORDS = 256;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned NUM_CMD = 16;
   localparam int unsigned QUAL_W = 8;

   // operation field, {command_enable_bit, jump_polarity_bit}
   localparam logic [1:0] OP_CMD_COUNT = 2'b00;
   localparam logic [1:0] OP_CMD_JUMP = 2'b01;
   localparam logic [1:0] OP_QUAL_HIGH = 2'b11;
   localparam logic [1:0] OP_QUAL_LOW = 2'b10;

   // command codes
   localparam logic [3:0] CMD_TIMER_START = 4'h0;
   localparam logic [3:0] CMD_CLK_LATCH = 4'h6;
   localparam logic [3:0] CMD_STOP_LEVEL_LOAD = 4'h9;

   // fixed qualifier lines
   localparam logic [2:0] GND_LINE_A = 3'h0;
   localparam logic [2:0] GND_LINE_B = 3'h6;
   localparam logic [2:0] TIMER_LINE_B = 3'h7;

   // one-shot interval
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned TIMER_NS = 20000;
   localparam int unsigned TIMER_CYC = (TIMER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ROM_ADDR = 8'h04;
   localparam logic [7:0] REG_ROM_DATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam int unsigned CTRL_RUN_BIT = 0;
   localparam int unsigned CTRL_INV_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'b00;
   localparam logic [7:0] ROM_ADDR_RESET = 8'h00;
   localparam logic [STATE_W-1:0] STATE_RESET = 8'h00;
   localparam logic [15:0] STROBE_IDLE = 16'hFFFF;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic cmd_en_n;          // command_enable_bit, low = command
      logic jump_polarity;     // jump_polarity_bit
      logic [3:0] sel;         // command code, or bank qualifier + line
      logic spare;
      logic bank_select;       // qualifier_bank_select, low = bank b
      logic [7:0] jump_addr;
   } rom_word_s;

   typedef enum logic {PH_EXEC, PH_QUAL} phase_e;
endpackage

// [core/nibble_counter.sv]
// four-bit loadable counter slice with carry out
`timescale 1ns/1ps
module nibble_counter (
   input wire logic i_clk,         // main clock
   input wire logic i_srst,        // synchronous reset
   input wire logic i_en,          // count one step
   input wire logic i_load,        // parallel load
   input wire logic [3:0] i_d,     // load value
   output logic [3:0] o_q,         // count
   output logic o_carry            // count step that wraps
);
   logic [3:0] q_r;
   logic [3:0] q_nxt;

   assign o_q = q_r;
   assign o_carry = i_en & (q_r == 4'hF);

   always_comb begin
      q_nxt = q_r;
      if (i_load) begin
         q_nxt = i_d;
      end else if (i_en) begin
         q_nxt = q_r + 4'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         q_r <= 4'h0;
      end else begin
         q_r <= q_nxt;
      end
   end

   a_nibble_load: assert property (@(posedge i_clk) disable iff (i_srst)
      i_load |=> q_r == $past(i_d))
      else $error("nibble load missed");
endmodule

// [core/oneshot_timer.sv]
// retriggerable-free one-shot interval timer
`timescale 1ns/1ps
module oneshot_timer #(
   parameter int unsigned CYCLES = useq_pkg::TIMER_CYC  // interval length in clocks
) (
   input wire logic i_clk,         // main clock
   input wire logic i_srst,        // synchronous reset
   input wire logic i_trig_n,      // start, active low
   output logic o_busy             // high during interval
);
   import useq_pkg::*;
   localparam int unsigned CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LOAD_VAL = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic busy_r;
   logic busy_nxt;

   assign o_busy = busy_r;

   // a trigger during the interval is ignored
   always_comb begin
      cnt_nxt = cnt_r;
      busy_nxt = busy_r;
      if (!busy_r) begin
         if (!i_trig_n) begin
            busy_nxt = 1'b1;
            cnt_nxt = LOAD_VAL;
         end
      end else if (cnt_r == '0) begin
         busy_nxt = 1'b0;
      end else begin
         cnt_nxt = cnt_r - CW'(1);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cnt_r <= '0;
         busy_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         busy_r <= busy_nxt;
      end
   end

   a_timer_start: assert property (@(posedge i_clk) disable iff (i_srst)
      (!i_trig_n && !busy_r) |=> busy_r)
      else $error("timer did not start");
endmodule

// [core/rom_microsequencer.sv]
// rom-driven microsequencer with axi4-lite program and status access
// Operation
// - eight-bit state counter 0..255 built from two nibble counters
// - upper nibble advances only on lower nibble carry
// - load low jumps to word bits 7:0, else increment by one
// - program store 256 words of 16 bits addressed by state
// - bits 15:14 pick command/count, command/jump, test-high, test-low
// - bit 15 low issues a one-cycle low strobe chosen by bits 13:10
// - code 0110 is latch clock, code 1001 is stop-level load
// - command words preset qualifier bit; bit 14 alone picks count or jump
// - bit 8 low enables bank b, bits 12:10 pick the line
// - selected line passes xor stage and is stored on the clock
// - load control is bit 14 xor stored qualifier bit
// - qualifier tests issue no strobe and leave qualifier capture free
// - one line of each bank is tied low for fixed outcomes
// - low trigger starts one-shot timer, high output feeds bank b
// - one main clock drives counter, decoder, selectors and flip-flop
// - after reset the program starts at state 0
`timescale 1ns/1ps
module rom_microsequencer #(
   parameter int unsigned TIMER_CYCLES = useq_pkg::TIMER_CYC  // one-shot length
) (
   input wire logic I_MCLK,                  // main clock, 50 MHz
   input wire logic I_SRST,                  // synchronous reset, high
   input wire logic [7:0] I_AWADDR,          // write address
   input wire logic I_AWVALID,               // write address valid
   output logic O_AWREADY,                   // write address ready
   input wire logic [31:0] I_WDATA,          // write data
   input wire logic [3:0] I_WSTRB,           // write byte enables
   input wire logic I_WVALID,                // write data valid
   output logic O_WREADY,                    // write data ready
   output logic [1:0] O_BRESP,               // write response
   output logic O_BVALID,                    // write response valid
   input wire logic I_BREADY,                // write response ready
   input wire logic [7:0] I_ARADDR,          // read address
   input wire logic I_ARVALID,               // read address valid
   output logic O_ARREADY,                   // read address ready
   output logic [31:0] O_RDATA,              // read data
   output logic [1:0] O_RRESP,               // read response
   output logic O_RVALID,                    // read data valid
   input wire logic I_RREADY,                // read data ready
   input wire logic [7:0] I_QUAL_A,          // qualifier bank a pins
   input wire logic [7:0] I_QUAL_B,          // qualifier bank b pins
   output logic [useq_pkg::NUM_CMD-1:0] O_CMD_N, // command strobes, low
   output logic O_TIMER_BUSY                 // one-shot running
);
   import useq_pkg::*;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   logic [WORD_W-1:0] rom [ROM_WORDS];
   logic [STATE_W-1:0] state;
   rom_word_s word;
   logic [3:0] lo_q, hi_q;
   logic lo_carry, timer_busy;
   logic [7:0] qa_s1_r, qa_s2_r, qb_s1_r, qb_s2_r;

   // sequencer state
   phase_e phase_r, phase_nxt;
   logic q_r, q_nxt;
   logic [NUM_CMD-1:0] cmd_n_r, cmd_n_nxt;
   logic step, load_n, q_eff, line, is_cmd, timer_trig_n;
   logic [7:0] bank_a, bank_b;

   // bus state
   logic [1:0] ctrl_r, ctrl_nxt;
   logic [7:0] rom_addr_r, rom_addr_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [7:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, ctrl_w, addr_w, data_w;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
   logic rom_we;

   assign state = {hi_q, lo_q};
   assign word = rom_word_s'(rom[state]);
   assign is_cmd = !word.cmd_en_n;
   assign step = ctrl_r[CTRL_RUN_BIT] & (is_cmd | (phase_r == PH_QUAL));
   assign q_eff = is_cmd ? 1'b1 : q_r;
   assign load_n = word.jump_polarity ^ q_eff;

   nibble_counter u_lo (
      .i_clk(I_MCLK),
      .i_srst(I_SRST),
      .i_en(step & load_n),
      .i_load(step & !load_n),
      .i_d(word.jump_addr[3:0]),
      .o_q(lo_q),
      .o_carry(lo_carry)
   );

   nibble_counter u_hi (
      .i_clk(I_MCLK),
      .i_srst(I_SRST),
      .i_en(lo_carry),
      .i_load(step & !load_n),
      .i_d(word.jump_addr[7:4]),
      .o_q(hi_q),
      .o_carry()
   );

   oneshot_timer #(
      .CYCLES(TIMER_CYCLES)
   ) u_timer (
      .i_clk(I_MCLK),
      .i_srst(I_SRST),
      .i_trig_n(timer_trig_n),
      .o_busy(timer_busy)
   );

   // qualifier banks with fixed lines
   always_comb begin
      bank_a = qa_s2_r;
      bank_a[GND_LINE_A] = 1'b0;
      bank_b = qb_s2_r;
      bank_b[GND_LINE_B] = 1'b0;
      bank_b[TIMER_LINE_B] = timer_busy;
      // bank a needs bit 13 high; neither bank enabled reads low
      if (!word.bank_select) begin
         line = bank_b[word.sel[2:0]];
      end else if (word.sel[3]) begin
         line = bank_a[word.sel[2:0]];
      end else begin
         line = 1'b0;
      end
   end

   always_comb begin
      phase_nxt = phase_r;
      q_nxt = q_r;
      cmd_n_nxt = STROBE_IDLE;
      if (ctrl_r[CTRL_RUN_BIT]) begin
         if (is_cmd) begin
            q_nxt = 1'b1;
            cmd_n_nxt[word.sel] = 1'b0;
            phase_nxt = PH_EXEC;
         end else if (phase_r == PH_EXEC) begin
            q_nxt = line ^ ctrl_r[CTRL_INV_BIT];
            phase_nxt = PH_QUAL;
         end else begin
            phase_nxt = PH_EXEC;
         end
      end
   end
   assign timer_trig_n = cmd_n_nxt[CMD_TIMER_START];

   // one clock for counter, decoder, selectors and qualifier bit
   always_ff @(posedge I_MCLK) begin
      qa_s1_r <= I_QUAL_A;
      qa_s2_r <= qa_s1_r;
      qb_s1_r <= I_QUAL_B;
      qb_s2_r <= qb_s1_r;
      if (I_SRST) begin
         phase_r <= PH_EXEC;
         q_r <= 1'b0;
         cmd_n_r <= STROBE_IDLE;
      end else begin
         phase_r <= phase_nxt;
         q_r <= q_nxt;
         cmd_n_r <= cmd_n_nxt;
      end
   end

   // register slave; one write and one read outstanding
   assign ctrl_w = merge({30'h0, ctrl_r}, wdata_r, wstrb_r);
   assign addr_w = merge({24'h0, rom_addr_r}, wdata_r, wstrb_r);
   assign data_w = merge({16'h0, rom[rom_addr_r]}, wdata_r, wstrb_r);
   assign rom_we = !awready_r && !wready_r && !bvalid_r && (awaddr_r == REG_ROM_DATA);

   always_comb begin
      awready_nxt = awready_r;
      wready_nxt = wready_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      ctrl_nxt = ctrl_r;
      rom_addr_nxt = rom_addr_r;
      arready_nxt = arready_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (awready_r && I_AWVALID) begin
         awready_nxt = 1'b0;
         awaddr_nxt = I_AWADDR;
      end
      if (wready_r && I_WVALID) begin
         wready_nxt = 1'b0;
         wdata_nxt = I_WDATA;
         wstrb_nxt = I_WSTRB;
      end
      if (!awready_r && !wready_r && !bvalid_r) begin
         bvalid_nxt = 1'b1;
         bresp_nxt = RESP_OKAY;
         case (awaddr_r)
            REG_CTRL: ctrl_nxt = ctrl_w[1:0];
            REG_ROM_ADDR: rom_addr_nxt = addr_w[7:0];
            // auto-increment so a program loads with back-to-back writes
            REG_ROM_DATA: rom_addr_nxt = rom_addr_r + 8'h01;
            REG_STATUS: bresp_nxt = RESP_OKAY;
            default: bresp_nxt = RESP_SLVERR;
         endcase
      end
      if (bvalid_r && I_BREADY) begin
         bvalid_nxt = 1'b0;
         awready_nxt = 1'b1;
         wready_nxt = 1'b1;
      end
      if (arready_r && I_ARVALID) begin
         arready_nxt = 1'b0;
         rvalid_nxt = 1'b1;
         rresp_nxt = RESP_OKAY;
         case (I_ARADDR)
            REG_CTRL: rdata_nxt = {30'h0, ctrl_r};
            REG_ROM_ADDR: rdata_nxt = {24'h0, rom_addr_r};
            REG_ROM_DATA: rdata_nxt = {16'h0, rom[rom_addr_r]};
            REG_STATUS: rdata_nxt = {21'h0, phase_r, timer_busy, q_r, state};
            default: begin
               rdata_nxt = 32'h0000_0000;
               rresp_nxt = RESP_SLVERR;
            end
         endcase
      end
      if (rvalid_r && I_RREADY) begin
         rvalid_nxt = 1'b0;
         arready_nxt = 1'b1;
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (rom_we) begin
         rom[rom_addr_r] <= data_w[WORD_W-1:0];
      end
      if (I_SRST) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         ctrl_r <= CTRL_RESET;
         rom_addr_r <= ROM_ADDR_RESET;
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else begin
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         ctrl_r <= ctrl_nxt;
         rom_addr_r <= rom_addr_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign O_AWREADY = awready_r;
   assign O_WREADY = wready_r;
   assign O_BVALID = bvalid_r;
   assign O_BRESP = bresp_r;
   assign O_ARREADY = arready_r;
   assign O_RVALID = rvalid_r;
   assign O_RDATA = rdata_r;
   assign O_RRESP = rresp_r;
   assign O_CMD_N = cmd_n_r;
   assign O_TIMER_BUSY = timer_busy;

   a_reset_strobe_idle: assert property (@(posedge I_MCLK)
      I_SRST |=> (O_CMD_N == STROBE_IDLE) && (state == STATE_RESET) && !q_r)
      else $error("reset left state or strobes active");
   a_cmd_one_strobe: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      (ctrl_r[CTRL_RUN_BIT] && is_cmd) |=> O_CMD_N == ~(16'h0001 << $past(word.sel)))
      else $error("wrong command strobe");
   a_cmd_count_step: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      (ctrl_r[CTRL_RUN_BIT] && {word.cmd_en_n, word.jump_polarity} == OP_CMD_COUNT)
      |=> state == 8'($past(state) + 8'h01))
      else $error("command and count did not increment");
   a_cmd_jump_load: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      (ctrl_r[CTRL_RUN_BIT] && {word.cmd_en_n, word.jump_polarity} == OP_CMD_JUMP)
      |=> state == $past(word.jump_addr) && q_r)
      else $error("command and jump did not load");
   a_qual_hold_state: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      (ctrl_r[CTRL_RUN_BIT] && !is_cmd && phase_r == PH_EXEC)
      |=> $stable(state) && phase_r == PH_QUAL && O_CMD_N == STROBE_IDLE)
      else $error("qualifier test moved early or strobed");
   a_qual_decide: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      (ctrl_r[CTRL_RUN_BIT] && !is_cmd && phase_r == PH_QUAL)
      |=> state == ($past(word.jump_polarity ^ q_r) ? 8'($past(state) + 8'h01)
                    : $past(word.jump_addr)))
      else $error("qualifier decision wrong");
   a_gnd_line_low: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      (ctrl_r[CTRL_RUN_BIT] && !is_cmd && phase_r == PH_EXEC && !word.bank_select
       && word.sel[2:0] == GND_LINE_B) |=> q_r == $past(ctrl_r[CTRL_INV_BIT]))
      else $error("grounded line not low");
   a_carry_cascade: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      (step && load_n && lo_q == 4'hF) |=> hi_q == 4'($past(hi_q) + 4'h1))
      else $error("upper nibble missed carry");
endmodule

// [bench/useq_far_side.sv]
// far-side model: command latches and qualifier input lines
`timescale 1ns/1ps
module useq_far_side (
   input wire logic i_clk,           // main clock
   input wire logic i_srst,          // reset, clears the tallies
   input wire logic [15:0] i_cmd_n,  // command strobes, low
   input wire logic i_busy,          // one-shot output
   input wire logic i_line_c,        // level of the tested bank a line
   output logic [7:0] o_qual_a,      // bank a pins
   output logic [7:0] o_qual_b,      // bank b pins
   output int o_latch_cnt,           // latch-clock strobes seen
   output int o_stop_cnt,            // stop-level load strobes seen
   output int o_start_cnt,           // timer start strobes seen
   output int o_other_cnt,           // strobes on any other line
   output int o_wide_cnt,            // strobes lasting over one cycle
   output int o_busy_cnt             // cycles with the one-shot high
);
   logic tog = 1'b0;
   logic [15:0] last_n = 16'hFFFF;
   // unused lines toggle so a stale level never looks like a real one
   // pins under the internal ground lines sit high so a missed tie shows
   assign o_qual_a = {{4{tog}}, i_line_c, tog, tog, 1'b1};
   assign o_qual_b = {tog, 1'b1, {6{tog}}};
   always @(posedge i_clk) begin
      tog <= ~tog;
      last_n <= i_cmd_n;
      if (i_srst) begin
         {o_latch_cnt, o_stop_cnt, o_start_cnt} <= '0;
         {o_other_cnt, o_wide_cnt, o_busy_cnt} <= '0;
      end else begin
         for (int i = 0; i < 16; i++) begin
            if (!i_cmd_n[i] && !last_n[i]) o_wide_cnt <= o_wide_cnt + 1;
         end
         if (!i_cmd_n[6]) o_latch_cnt <= o_latch_cnt + 1;
         if (!i_cmd_n[9]) o_stop_cnt <= o_stop_cnt + 1;
         if (!i_cmd_n[0]) o_start_cnt <= o_start_cnt + 1;
         if ((~i_cmd_n & 16'hFDBE) != 16'h0000) o_other_cnt <= o_other_cnt + 1;
         if (i_busy) o_busy_cnt <= o_busy_cnt + 1;
      end
   end
endmodule

// [bench/test_rom_microsequencer.sv]
// self-checking bench for the rom microsequencer
`timescale 1ns/1ps
module test_rom_microsequencer;
   import useq_pkg::*;
   localparam int unsigned TCYC = 8;
   logic clk = 1'b0, srst = 1'b1, line_c = 1'b0;
   logic [7:0] awaddr = '0, araddr = '0, qa, qb;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, busy;
   logic [1:0] bresp, rresp;
   logic [15:0] cmd_n;
   int latch_cnt, stop_cnt, start_cnt, other_cnt, wide_cnt, busy_cnt;
   int miscompares = 0, total_checks = 0;
   always #10 clk = ~clk;
   rom_microsequencer #(.TIMER_CYCLES(TCYC)) u_dut (.I_MCLK(clk), .I_SRST(srst),
      .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
      .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
      .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
      .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
      .I_RREADY(rready), .I_QUAL_A(qa), .I_QUAL_B(qb), .O_CMD_N(cmd_n),
      .O_TIMER_BUSY(busy));
   useq_far_side u_far (.i_clk(clk), .i_srst(srst), .i_cmd_n(cmd_n), .i_busy(busy),
      .i_line_c(line_c), .o_qual_a(qa), .o_qual_b(qb), .o_latch_cnt(latch_cnt),
      .o_stop_cnt(stop_cnt), .o_start_cnt(start_cnt), .o_other_cnt(other_cnt),
      .o_wide_cnt(wide_cnt), .o_busy_cnt(busy_cnt));
   task automatic test_done();
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic hang(input string what);
      miscompares++;
      $display("unexpected %s wait expected done seen timeout", what);
      test_done();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
      int n;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (n == 50) hang("write");
      bready <= 1'b0;
      chk("bresp", {30'h0000_0000, bresp}, {30'h0000_0000, exp});
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] exp);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (n == 50) hang("read");
      d = rdata;
      rready <= 1'b0;
      chk("rresp", {30'h0000_0000, rresp}, {30'h0000_0000, exp});
   endtask
   // program: latch clock, timer start, stop load and jump, then tests
   // 0x12 parks on an unselected bank; only the inverted run reaches it
   logic [7:0] pa [8] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h06, 8'h10, 8'h11, 8'h12};
   logic [15:0] pw [8] = '{16'h1800, 16'h0000, 16'h6405, 16'hED10, 16'h9806,
      16'hDC10, 16'hA111, 16'hC112};
   task automatic run(input logic lvl, input logic inv, input logic [7:0] exp_state);
      logic [31:0] st;
      int n;
      @(posedge clk);
      srst <= 1'b1;
      line_c <= lvl;
      @(posedge clk);
      srst <= 1'b0;
      rd(REG_STATUS, st, RESP_OKAY);
      chk("state after reset", st[7:0], STATE_RESET);
      chk("strobes in reset", cmd_n, STROBE_IDLE);
      wr(REG_CTRL, {30'h0000_0000, inv, 1'b1}, RESP_OKAY);
      for (n = 0; n < 100; n++) begin
         rd(REG_STATUS, st, RESP_OKAY);
         if (st[7:0] === exp_state && st[9] === 1'b0) break;
      end
      if (n == 100) hang("sequencer");
      chk("final state", st[7:0], exp_state);
      chk("latch strobes", latch_cnt, 1);
      chk("stop strobes", stop_cnt, 1);
      chk("start strobes", start_cnt, 1);
      chk("other strobes", other_cnt, 0);
      chk("long strobes", wide_cnt, 0);
      chk("busy cycles", busy_cnt, TCYC);
      wr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
      $display("run with line %0d invert %0d done", lvl, inv);
   endtask
   initial begin
      logic [31:0] v;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      chk("strobes after reset", cmd_n, STROBE_IDLE);
      rd(REG_CTRL, v, RESP_OKAY);
      chk("ctrl reset", v, {30'h0000_0000, CTRL_RESET});
      rd(REG_STATUS, v, RESP_OKAY);
      chk("status reset", v[8:0], 9'h000);
      rd(8'h10, v, RESP_SLVERR);
      chk("unmapped read", v, 32'h0000_0000);
      wr(8'h14, 32'h0000_0001, RESP_SLVERR);
      wr(REG_STATUS, 32'h0000_00FF, RESP_OKAY);
      rd(REG_STATUS, v, RESP_OKAY);
      chk("status read only", v[7:0], 8'h00);
      $display("register test done");
      for (int i = 0; i < 8; i++) begin
         wr(REG_ROM_ADDR, {24'h00_0000, pa[i]}, RESP_OKAY);
         wr(REG_ROM_DATA, {16'h0000, pw[i]}, RESP_OKAY);
         rd(REG_ROM_ADDR, v, RESP_OKAY);
         chk("rom address step", v[7:0], pa[i] + 8'h01);
      end
      wr(REG_ROM_ADDR, 32'h0000_0005, RESP_OKAY);
      rd(REG_ROM_DATA, v, RESP_OKAY);
      chk("rom readback", v[15:0], 16'hED10);
      $display("program load test done");
      // line high: jump to 0x10, wait out the timer, park at 0x11
      run(1'b1, 1'b0, 8'h11);
      // line low: count on to 0x06 and park on the bank b ground line
      run(1'b0, 1'b0, 8'h06);
      // line low inverted: jump to 0x10, step past busy and 0x11, park at 0x12
      run(1'b0, 1'b1, 8'h12);
      test_done();
   end
   initial begin
      repeat (90000) @(posedge clk);
      hang("overall");
   end
endmodule
